// *** verilog/dmc_debug_ctrl.sv ***
// Debug mode control: entry and exit, freezes, debug pins, registers.
//
// Overview of operation
// - Break instruction or low break on data pin enters debug until return.
// - In debug mode hardware interrupt requests and the NMI are blocked.
// - Prescaler and slow oscillator peripherals other than the 8-bit timer halt in debug mode by default, unless a run bit is set.
// - Display driver keeps running in debug mode regardless of settings.
// - Prescaler run bit D1 keeps prescaler peripherals running when set.
// - Slow oscillator run bit D0 keeps its timers running in debug.
// - The slow oscillator 8-bit timer is never frozen by debug mode.
// - Pins default to debug use; select bits D1..D3 hand them to ports.
// - Clock and status drive the probe; data pin is two-way and breaks.
// - Work area 0xfc0 to 0xfff is reserved; application use is flagged.
// - Work area base register reads 0xfc0 with upper byte zero.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/100ps
module dmc_debug_ctrl #(
    parameter int unsigned DBG_CLK_HALF = dmc_pkg::DMC_DBG_CLK_HALF
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Register bus.
    input dmc_pkg::dmc_wb_req_t wb_req_i,
    output dmc_pkg::dmc_wb_rsp_t wb_rsp_o,
    // Core side.
    input wire logic brk_exec_i,
    input wire logic retd_exec_i,
    input wire logic cpu_status_i,
    input wire logic dbg_tx_data_i,
    input wire logic dbg_tx_en_i,
    output logic dbg_rx_data_o,
    output logic dbg_irq_o,
    output logic dbg_mode_o,
    input wire logic hw_irq_i,
    input wire logic nmi_i,
    output logic hw_irq_o,
    output logic nmi_o,
    input wire logic core_acc_i,
    input wire logic [dmc_pkg::DMC_CORE_ADR_W-1:0] core_addr_i,
    output logic work_area_hit_o,
    // Peripheral freezes.
    output logic presc_freeze_o,
    output logic slow_osc_freeze_o,
    output logic slow_timer8_freeze_o,
    output logic display_freeze_o,
    // General-purpose port side of lines 1 to 3.
    input wire logic [3:1] port3_out_i,
    input wire logic [3:1] port3_oe_i,
    output logic [3:1] port3_in_o,
    // Debug clock pin.
    input wire logic dbg_clock_out_i,
    output logic dbg_clock_out_o,
    output logic dbg_clock_out_oe_o,
    // Debug status pin.
    input wire logic dbg_status_out_i,
    output logic dbg_status_out_o,
    output logic dbg_status_out_oe_o,
    // Debug data pin.
    input wire logic dbg_data_io_i,
    output logic dbg_data_io_o,
    output logic dbg_data_io_oe_o
);
    import dmc_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    dmc_state_t s_q;
    dmc_state_t s_d;
    logic clk_tick;
    logic req_new;
    logic brk_pin;
    logic [DMC_IDX_W-1:0] idx;

    if (DBG_CLK_HALF < 2) begin : g_chk
        $error("dmc_debug_ctrl: DBG_CLK_HALF must be at least 2");
    end

    // ************************************************************
    // Debug clock divider
    // ************************************************************
    // The divider only runs while the clock pin belongs to the debugger,
    // so a pin handed to the port draws no toggling from this block.
    dmc_divider #(
        .DIV(DBG_CLK_HALF)
    ) u_clk_div (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .en_i(!s_q.pmux[0]),
        .tick_o(clk_tick)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    assign idx = wb_req_i.adr[DMC_ADR_W-1:2];
    assign req_new = wb_req_i.cyc && wb_req_i.stb && !s_q.ack;
    // A break is only seen while the probe owns the line and we are not
    // driving it ourselves, so our own low data bits cannot break.
    assign brk_pin = !s_q.pmux[2] && !dbg_data_io_oe_o && !dbg_data_io_i;

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.dbg_irq = 1'b0;
        if (req_new) begin
            s_d.ack = 1'b1;
            s_d.rdat = '0;
            case (idx)
                DMC_IDX_PRESC_CTRL: begin
                    s_d.rdat[DMC_PRESC_RUN_BIT] = s_q.presc_run;
                    if (wb_req_i.we && wb_req_i.sel[0]) begin
                        s_d.presc_run = wb_req_i.dat[DMC_PRESC_RUN_BIT];
                    end
                end
                DMC_IDX_OSC_CTRL: begin
                    s_d.rdat[DMC_OSC_RUN_BIT] = s_q.osc_run;
                    if (wb_req_i.we && wb_req_i.sel[0]) begin
                        s_d.osc_run = wb_req_i.dat[DMC_OSC_RUN_BIT];
                    end
                end
                DMC_IDX_PORT3_FSEL: begin
                    s_d.rdat[DMC_DATA_SEL_BIT:DMC_CLK_SEL_BIT] = s_q.pmux;
                    if (wb_req_i.we && wb_req_i.sel[0]) begin
                        s_d.pmux = wb_req_i.dat[DMC_DATA_SEL_BIT:
                                                DMC_CLK_SEL_BIT];
                    end
                end
                DMC_IDX_DBG_STATUS: begin
                    s_d.rdat[DMC_MODE_BIT] = (s_q.mode == DMC_DEBUG);
                end
                DMC_IDX_WORK_BASE: begin
                    s_d.rdat = DMC_WORK_BASE_VAL;
                end
                default: begin
                    s_d.rdat = '0;
                end
            endcase
        end

        case (s_q.mode)
            DMC_RUN: begin
                if (brk_exec_i || brk_pin) begin
                    s_d.mode = DMC_DEBUG;
                    s_d.dbg_irq = 1'b1;
                end
            end
            DMC_DEBUG: begin
                if (retd_exec_i) begin
                    s_d.mode = DMC_RUN;
                end
            end
            default: begin
                s_d.mode = DMC_RUN;
            end
        endcase

        // Freezes follow the next mode so they switch on the same edge.
        s_d.presc_frz = (s_d.mode == DMC_DEBUG) && !s_d.presc_run;
        s_d.osc_frz = (s_d.mode == DMC_DEBUG) && !s_d.osc_run;

        if (clk_tick) begin
            s_d.dbg_clk = !s_q.dbg_clk;
        end else if (s_q.pmux[0]) begin
            s_d.dbg_clk = 1'b0;
        end
        s_d.status_out = cpu_status_i;
        s_d.rx_data = dbg_data_io_i;
        s_d.port_in = {dbg_data_io_i, dbg_status_out_i, dbg_clock_out_i};
        s_d.area_hit = core_acc_i && (s_q.mode == DMC_RUN)
                     && (core_addr_i >= DMC_WORK_FIRST)
                     && (core_addr_i <= DMC_WORK_LAST);
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
            s_q.presc_run <= DMC_PRESC_RUN_RST;
            s_q.osc_run <= DMC_OSC_RUN_RST;
            s_q.pmux <= DMC_PMUX_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign wb_rsp_o.ack = s_q.ack;
    assign wb_rsp_o.dat = s_q.rdat;
    assign dbg_mode_o = (s_q.mode == DMC_DEBUG);
    assign dbg_irq_o = s_q.dbg_irq;
    assign dbg_rx_data_o = s_q.rx_data;
    assign hw_irq_o = hw_irq_i && (s_q.mode != DMC_DEBUG);
    assign nmi_o = nmi_i && (s_q.mode != DMC_DEBUG);
    assign work_area_hit_o = s_q.area_hit;
    assign presc_freeze_o = s_q.presc_frz;
    assign slow_osc_freeze_o = s_q.osc_frz;
    // The 8-bit slow timer and the display driver ignore debug mode.
    assign slow_timer8_freeze_o = 1'b0;
    assign display_freeze_o = 1'b0;
    assign port3_in_o = s_q.port_in;

    // Pin ownership: debugger after reset, port once its select bit is set.
    assign dbg_clock_out_o = s_q.pmux[0] ? port3_out_i[1] : s_q.dbg_clk;
    assign dbg_clock_out_oe_o = s_q.pmux[0] ? port3_oe_i[1] : 1'b1;
    assign dbg_status_out_o = s_q.pmux[1] ? port3_out_i[2] : s_q.status_out;
    assign dbg_status_out_oe_o = s_q.pmux[1] ? port3_oe_i[2] : 1'b1;
    assign dbg_data_io_o = s_q.pmux[2] ? port3_out_i[3] : dbg_tx_data_i;
    assign dbg_data_io_oe_o = s_q.pmux[2] ? port3_oe_i[3] : dbg_tx_en_i;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    enter_on_brk_a: assert property (
        (!dbg_mode_o && brk_exec_i) |=> (dbg_mode_o && dbg_irq_o))
        else $error("break instruction did not enter debug mode");

    stay_in_debug_a: assert property (
        (dbg_mode_o && !retd_exec_i) |=> (dbg_mode_o && !dbg_irq_o))
        else $error("debug mode left without return");

    exit_on_retd_a: assert property (
        (dbg_mode_o && retd_exec_i) |=> !dbg_mode_o)
        else $error("return did not leave debug mode");

    irq_blocked_a: assert property (
        (dbg_mode_o && (hw_irq_i || nmi_i)) |-> !(hw_irq_o || nmi_o))
        else $error("interrupt passed in debug mode");

    presc_freeze_a: assert property (
        ($rose(dbg_mode_o) && !s_q.presc_run) |-> presc_freeze_o)
        else $error("prescaler not frozen on debug entry");

    osc_freeze_a: assert property (
        slow_osc_freeze_o == (dbg_mode_o && !s_q.osc_run))
        else $error("slow oscillator freeze wrong");

    timer8_runs_a: assert property (
        dbg_mode_o |-> !slow_timer8_freeze_o && !display_freeze_o)
        else $error("timer or display frozen in debug");

    base_read_a: assert property (
        (req_new && !wb_req_i.we && idx == DMC_IDX_WORK_BASE)
        |=> (wb_rsp_o.ack && wb_rsp_o.dat == 32'h00000FC0))
        else $error("work area base read wrong");

    rsvd_zero_a: assert property (
        (req_new && idx == DMC_IDX_OSC_CTRL)
        |=> (wb_rsp_o.dat[31:1] == 31'h0))
        else $error("reserved bits not zero");

    pin_owned_a: assert property (
        !s_q.pmux[0] |-> dbg_clock_out_oe_o)
        else $error("debug clock pin not driven");

    ack_one_a: assert property (
        wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");

    work_hit_a: assert property (
        (core_acc_i && !dbg_mode_o && (core_addr_i >= DMC_WORK_FIRST)
         && (core_addr_i <= DMC_WORK_LAST)) |=> work_area_hit_o)
        else $error("work area access not flagged");

endmodule : dmc_debug_ctrl

// *** inc/dmc_pkg.sv ***
// Constants, types and register map of the debug mode control block.
package dmc_pkg;

    // ************************************************************
    // Clock and bus geometry
    // ************************************************************
    localparam int unsigned DMC_REF_CLK_HZ = 25_000_000;
    localparam int unsigned DMC_ADR_W = 26;
    localparam int unsigned DMC_IDX_W = DMC_ADR_W - 2;
    localparam int unsigned DMC_DAT_W = 32;
    localparam int unsigned DMC_SEL_W = DMC_DAT_W / 8;

    // Half period of the debug clock in reference clock cycles.
    localparam int unsigned DMC_DBG_CLK_HALF = 2;

    // ************************************************************
    // Register indices; the byte address is four times the index
    // ************************************************************
    localparam logic [DMC_IDX_W-1:0] DMC_IDX_PRESC_CTRL = 24'h004020;
    localparam logic [DMC_IDX_W-1:0] DMC_IDX_PORT3_FSEL = 24'h0052A3;
    localparam logic [DMC_IDX_W-1:0] DMC_IDX_OSC_CTRL = 24'h005322;
    localparam logic [DMC_IDX_W-1:0] DMC_IDX_DBG_STATUS = 24'h005330;
    localparam logic [DMC_IDX_W-1:0] DMC_IDX_WORK_BASE = 24'hFFFF90;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int unsigned DMC_PRESC_RUN_BIT = 1;
    localparam int unsigned DMC_OSC_RUN_BIT = 0;
    localparam int unsigned DMC_CLK_SEL_BIT = 1;
    localparam int unsigned DMC_STAT_SEL_BIT = 2;
    localparam int unsigned DMC_DATA_SEL_BIT = 3;
    localparam int unsigned DMC_MODE_BIT = 0;
    localparam logic DMC_PRESC_RUN_RST = 1'b0;
    localparam logic DMC_OSC_RUN_RST = 1'b0;
    localparam logic [2:0] DMC_PMUX_RST = 3'h0;

    // ************************************************************
    // Debugger work area
    // ************************************************************
    localparam int unsigned DMC_CORE_ADR_W = 24;
    localparam logic [DMC_CORE_ADR_W-1:0] DMC_WORK_FIRST = 24'h000FC0;
    localparam logic [DMC_CORE_ADR_W-1:0] DMC_WORK_LAST = 24'h000FFF;
    localparam logic [DMC_DAT_W-1:0] DMC_WORK_BASE_VAL = 32'h00000FC0;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [0:0] {
        DMC_RUN = 1'b0,
        DMC_DEBUG = 1'b1
    } dmc_mode_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [DMC_ADR_W-1:0] adr;
        logic [DMC_SEL_W-1:0] sel;
        logic [DMC_DAT_W-1:0] dat;
    } dmc_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [DMC_DAT_W-1:0] dat;
    } dmc_wb_rsp_t;

    typedef struct packed {
        logic ack;
        logic [DMC_DAT_W-1:0] rdat;
        dmc_mode_t mode;
        logic presc_run;
        logic osc_run;
        logic [2:0] pmux;
        logic presc_frz;
        logic osc_frz;
        logic dbg_irq;
        logic dbg_clk;
        logic rx_data;
        logic [2:0] port_in;
        logic status_out;
        logic area_hit;
    } dmc_state_t;

endpackage : dmc_pkg

// *** verilog/dmc_divider.sv ***
// Divider that issues a one-cycle enable pulse every DIV enabled cycles.
`timescale 1ns/100ps
module dmc_divider #(
    parameter int unsigned DIV = 2
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic en_i,
    output logic tick_o
);
    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } dmc_div_state_t;

    dmc_div_state_t s_q;
    dmc_div_state_t s_d;

    if (DIV < 2) begin : g_chk
        $error("dmc_divider: DIV must be at least 2");
    end

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!en_i) begin
            s_d.cnt = '0;
        end else if (s_q.cnt == LAST) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + CW'(1);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_o = s_q.tick;

endmodule : dmc_divider

// *** sim/dmc_probe_model.sv ***
// Behavioural model of the debugger probe that sits on the debug pins.
`timescale 1ns/100ps
module dmc_probe_model (
    input wire logic ref_clk_i,
    input wire logic brk_i,
    input wire logic clk_o_i,
    input wire logic clk_oe_i,
    input wire logic st_o_i,
    input wire logic st_oe_i,
    input wire logic dat_o_i,
    input wire logic dat_oe_i,
    output logic clk_pin_o,
    output logic st_pin_o,
    output logic dat_pin_o
);
    logic junk_q = 1'b0;

    // An undriven line without a pull-up shows a changing pattern, so a
    // design that reads a released pin cannot pass by the simulator's luck.
    always @(posedge ref_clk_i) begin
        junk_q <= ~junk_q;
    end

    // The probe only listens on the clock and status lines.
    assign clk_pin_o = clk_oe_i ? clk_o_i : junk_q;
    assign st_pin_o = st_oe_i ? st_o_i : junk_q;

    // The data line is pulled up; the probe breaks by pulling it low.
    assign dat_pin_o = dat_oe_i ? dat_o_i : !brk_i;
endmodule : dmc_probe_model

// *** sim/testbench.sv ***
// Self-checking testbench of the debug mode control block.
`timescale 1ns/100ps
module testbench;
    import dmc_pkg::*;

    typedef struct packed {
        logic we;
        logic [23:0] idx;
        logic [31:0] wd;
        logic [31:0] exp;
    } dmc_row_t;

    localparam logic [23:0] UNMAPPED = 24'h000100;
    localparam dmc_row_t ROWS [13] = '{
        '{1'b0, DMC_IDX_PRESC_CTRL, 32'h0, 32'h0},
        '{1'b0, DMC_IDX_PORT3_FSEL, 32'h0, 32'h0},
        '{1'b0, DMC_IDX_OSC_CTRL, 32'h0, 32'h0},
        '{1'b0, DMC_IDX_DBG_STATUS, 32'h0, 32'h0},
        '{1'b0, DMC_IDX_WORK_BASE, 32'h0, 32'h00000FC0},
        '{1'b0, UNMAPPED, 32'h0, 32'h0},
        '{1'b1, DMC_IDX_OSC_CTRL, 32'h1, 32'h1},
        '{1'b1, DMC_IDX_PRESC_CTRL, 32'hFFFFFFFF, 32'h2},
        '{1'b1, DMC_IDX_WORK_BASE, 32'hFFFFFFFF, 32'h00000FC0},
        '{1'b1, UNMAPPED, 32'hFFFFFFFF, 32'h0},
        '{1'b1, DMC_IDX_DBG_STATUS, 32'h1, 32'h0},
        '{1'b1, DMC_IDX_OSC_CTRL, 32'h0, 32'h0},
        '{1'b1, DMC_IDX_PRESC_CTRL, 32'h0, 32'h0}
    };

    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    dmc_wb_req_t wb_req = '0;
    dmc_wb_rsp_t wb_rsp;
    logic brk = 1'b0, retd = 1'b0, cpu_st = 1'b0, tx_d = 1'b0, tx_en = 1'b0;
    logic hw_irq = 1'b0, nmi = 1'b0, core_acc = 1'b0, probe_brk = 1'b0;
    logic [23:0] core_addr = 24'h0;
    logic [3:1] p3_out = 3'h0, p3_oe = 3'h0;
    logic rx, irq, mode, hw_o, nmi_o, hit, pfrz, ofrz, t8frz, dfrz;
    logic [3:1] p3_in;
    logic ck_o, ck_oe, st_o, st_oe, d_o, d_oe, ck_pin, st_pin, d_pin;
    logic [31:0] rd;
    logic prev;
    logic ack_s = 1'b0;
    logic [31:0] dat_s = 32'h0;
    logic [23:0] n_addr [4] = '{24'h000FBF, 24'h000FC0, 24'h000FFF,
                                24'h001000};
    int bad_count = 0;
    int checks = 0;
    int n;

    always #20 ref_clk_i = ~ref_clk_i;

    // Copies of the answer made mid-cycle, so the master sees at a rising
    // edge exactly what stood before it and never races the design.
    always @(negedge ref_clk_i) begin
        ack_s <= wb_rsp.ack;
        dat_s <= wb_rsp.dat;
    end

    dmc_debug_ctrl #(.DBG_CLK_HALF(2)) dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
        .brk_exec_i(brk), .retd_exec_i(retd), .cpu_status_i(cpu_st),
        .dbg_tx_data_i(tx_d), .dbg_tx_en_i(tx_en), .dbg_rx_data_o(rx),
        .dbg_irq_o(irq), .dbg_mode_o(mode), .hw_irq_i(hw_irq),
        .nmi_i(nmi), .hw_irq_o(hw_o), .nmi_o(nmi_o),
        .core_acc_i(core_acc), .core_addr_i(core_addr),
        .work_area_hit_o(hit), .presc_freeze_o(pfrz),
        .slow_osc_freeze_o(ofrz), .slow_timer8_freeze_o(t8frz),
        .display_freeze_o(dfrz), .port3_out_i(p3_out),
        .port3_oe_i(p3_oe), .port3_in_o(p3_in),
        .dbg_clock_out_i(ck_pin), .dbg_clock_out_o(ck_o),
        .dbg_clock_out_oe_o(ck_oe), .dbg_status_out_i(st_pin),
        .dbg_status_out_o(st_o), .dbg_status_out_oe_o(st_oe),
        .dbg_data_io_i(d_pin), .dbg_data_io_o(d_o),
        .dbg_data_io_oe_o(d_oe)
    );

    dmc_probe_model probe (
        .ref_clk_i(ref_clk_i), .brk_i(probe_brk),
        .clk_o_i(ck_o), .clk_oe_i(ck_oe), .st_o_i(st_o), .st_oe_i(st_oe),
        .dat_o_i(d_o), .dat_oe_i(d_oe), .clk_pin_o(ck_pin),
        .st_pin_o(st_pin), .dat_pin_o(d_pin)
    );

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic tally_and_finish;
        if (bad_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // Starts at the next rising edge, so a call always follows an idle
    // cycle; returns at the edge that took ack, with the request released.
    task automatic wb(input logic we, input logic [23:0] idx,
                      input logic [31:0] wd, output logic [31:0] r);
        int k;
        k = 0;
        @(posedge ref_clk_i);
        wb_req <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'hF, wd};
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (ack_s !== 1'b1 && k < 20);
        r = dat_s;
        wb_req <= '0;
        if (k >= 20) begin
            chk("ack timeout", 1, 0);
            tally_and_finish();
        end
    endtask : wb

    // One-cycle strobe: 0 break instruction, 1 return, 2 probe break.
    // Returns on the falling edge after the design has taken it.
    task automatic pulse(input int w);
        @(posedge ref_clk_i);
        brk <= (w == 0);
        retd <= (w == 1);
        probe_brk <= (w == 2);
        @(posedge ref_clk_i);
        brk <= 1'b0;
        retd <= 1'b0;
        probe_brk <= 1'b0;
        @(negedge ref_clk_i);
    endtask : pulse

    initial begin
        repeat (6) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        chk("mode", 0, mode);
        chk("freezes", 0, {pfrz, ofrz});
        chk("pin oe", 3'b110, {ck_oe, st_oe, d_oe});
        chk("rx", 1, rx);
        prev = ck_o;
        n = 0;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk_i);
            #1;
            if (ck_o !== prev) n++;
            prev = ck_o;
        end
        chk("clock edges", 4, n);
        @(posedge ref_clk_i);
        foreach (ROWS[i]) begin
            if (ROWS[i].we) wb(1'b1, ROWS[i].idx, ROWS[i].wd, rd);
            wb(1'b0, ROWS[i].idx, 32'h0, rd);
            chk("reg read", ROWS[i].exp, rd);
        end
        foreach (n_addr[i]) begin
            @(posedge ref_clk_i);
            core_acc <= 1'b1;
            core_addr <= n_addr[i];
            @(posedge ref_clk_i);
            @(negedge ref_clk_i);
            chk("work hit", i == 1 || i == 2, hit);
        end
        @(posedge ref_clk_i);
        core_acc <= 1'b0;
        // ************************************************************
        // Debug entry by break instruction, with default freezes
        // ************************************************************
        hw_irq <= 1'b1;
        nmi <= 1'b1;
        pulse(0);
        chk("entry", 4'b1111, {mode, irq, pfrz, ofrz});
        chk("never frozen", 0, {t8frz, dfrz});
        chk("irq gate", 0, {hw_o, nmi_o});
        @(negedge ref_clk_i);
        chk("irq pulse", 0, irq);
        @(posedge ref_clk_i);
        cpu_st <= 1'b1;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("status pin", 1, st_o);
        wb(1'b0, DMC_IDX_DBG_STATUS, 32'h0, rd);
        chk("status reg", 1, rd);
        pulse(0);
        chk("rebreak", 2'b10, {mode, irq});
        pulse(1);
        chk("exit", 5'b00011, {mode, pfrz, ofrz, hw_o, nmi_o});
        // ************************************************************
        // Entry by probe break on the data pin, both run bits set
        // ************************************************************
        wb(1'b1, DMC_IDX_PRESC_CTRL, 32'h2, rd);
        wb(1'b1, DMC_IDX_OSC_CTRL, 32'h1, rd);
        pulse(2);
        chk("pin entry", 4'b1100, {mode, irq, pfrz, ofrz});
        pulse(1);
        @(posedge ref_clk_i);
        tx_en <= 1'b1;
        tx_d <= 1'b0;
        @(negedge ref_clk_i);
        chk("data drive", 2'b10, {d_oe, d_o});
        wb(1'b1, DMC_IDX_PORT3_FSEL, 32'hE, rd);
        p3_out <= 3'b101;
        p3_oe <= 3'b011;
        @(negedge ref_clk_i);
        chk("port pins", 5'b11010, {ck_o, ck_oe, st_o, st_oe, d_oe});
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("port in", 3'b101, p3_in);
        // ************************************************************
        // Reset in mid-run gives the pins back and clears the prescaler run bit
        // ************************************************************
        @(posedge ref_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("reset pins", 3'b111, {ck_oe, st_oe, d_oe});
        wb(1'b0, DMC_IDX_PRESC_CTRL, 32'h0, rd);
        chk("reset run bit", 0, rd);
        tally_and_finish();
    end
endmodule : testbench
